// >>> scp_pkg.sv
// Shared constants and types for the three-wire serial control port
package scp_pkg;

  // Instruction word layout
  localparam int INSTR_BITS = 16;
  localparam int ADDR_W = 13;
  localparam int DIR_POS = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'b11;

  // Register space of the device
  localparam int NUM_REGS = 53;
  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_READBACK = 13'h0004;
  localparam logic [12:0] ADDR_UPDATE = 13'h0005;
  localparam logic [12:0] ADDR_LAST = 13'h0034;
  localparam int LSB_FIRST_HI = 6;
  localparam int LSB_FIRST_LO = 1;
  localparam int READBACK_BIT = 0;
  localparam int UPDATE_BIT = 0;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] REG_RST = 8'h00;
  // Registers that ignore writes and report user-side status
  localparam logic [NUM_REGS-1:0] READ_ONLY_MAP = 53'h0_0000_0000_000E;

  // Link clock made by the host
  localparam int SYS_CLK_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC =
    (SCLK_PERIOD_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);

  // Host register map on APB
  localparam logic [11:0] HOST_CTRL = 12'h000;
  localparam logic [11:0] HOST_TXDATA = 12'h004;
  localparam logic [11:0] HOST_RXDATA = 12'h008;
  localparam logic [11:0] HOST_STATUS = 12'h00C;
  localparam int CTRL_GO = 31;
  localparam int CTRL_LSB = 30;
  localparam int CTRL_CNT_LO = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;

  typedef enum logic [1:0] {
    SCP_IDLE = 2'b00,
    SCP_INSTR = 2'b01,
    SCP_DATA = 2'b10,
    SCP_DONE = 2'b11
  } scp_dev_state_type;

  typedef enum logic [2:0] {
    SCP_H_IDLE = 3'b000,
    SCP_H_SETUP = 3'b001,
    SCP_H_LOW = 3'b010,
    SCP_H_HIGH = 3'b011,
    SCP_H_END = 3'b100
  } scp_host_state_type;

endpackage : scp_pkg

// >>> scp_link_if.sv
// Three-wire link between serial master and device
`timescale 1ns/1ps
interface scp_link_if;
  logic sclk;
  logic cs_n;
  logic host_sdo;
  logic host_oe;
  logic dev_sdo;
  logic dev_oe;
  logic sdio;

  // Resolved shared data line, pulled high when nobody drives
  assign sdio = dev_oe ? dev_sdo : (host_oe ? host_sdo : 1'b1);

  modport host (
    output sclk,
    output cs_n,
    output host_sdo,
    output host_oe,
    input sdio
  );

  modport dev (
    input sclk,
    input cs_n,
    input sdio,
    output dev_sdo,
    output dev_oe
  );
endinterface : scp_link_if

// >>> scp_dev.sv
// Device end of the serial control port with staged register file
`timescale 1ns/1ps
module scp_dev
  import scp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  scp_link_if.dev link,
  input wire logic [7:0] ro_data,
  output logic [NUM_REGS*8-1:0] cfg_active,
  output logic update_pulse
);

  scp_dev_state_type state_q;
  logic [2:0] sync1_q, sync2_q, sync3_q, filt_q;
  logic sclk_prev_q, cs_prev_q;
  logic [3:0] cnt_q;
  logic [15:0] instr_q;
  logic dir_q, stream_q;
  logic [1:0] left_q;
  logic [12:0] addr_q;
  logic [7:0] wsh_q, rsh_q;
  logic sdo_q, oe_q, upd_q;
  logic [7:0] staged_q [NUM_REGS];
  logic [7:0] active_q [NUM_REGS];

  // Three-stage sampling of the pins; a level counts once stages agree
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Idle levels: data pulled high, select high, clock low
      sync1_q <= 3'h6;
      sync2_q <= 3'h6;
      sync3_q <= 3'h6;
      filt_q <= 3'h6;
    end else begin
      sync1_q <= {link.sdio, link.cs_n, link.sclk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & ~(sync2_q ^ sync3_q)) |
                (filt_q & (sync2_q ^ sync3_q));
    end
  end

  // Edge detection on the filtered link signals
  wire sclk_f = filt_q[0];
  wire cs_f = filt_q[1];
  wire sdio_f = filt_q[2];
  wire sclk_rise = sclk_f & ~sclk_prev_q & ~cs_f;
  wire sclk_fall = ~sclk_f & sclk_prev_q & ~cs_f;
  wire cs_fall = ~cs_f & cs_prev_q;
  wire cs_rise = cs_f & ~cs_prev_q;

  // Port configuration taken from the active registers
  wire lsb_first = active_q[0][LSB_FIRST_HI] | active_q[0][LSB_FIRST_LO];
  wire rd_staged = active_q[4][READBACK_BIT];

  // Shift paths honour the bit order for instruction and data
  wire [15:0] instr_next = lsb_first ? {sdio_f, instr_q[15:1]} :
                                       {instr_q[14:0], sdio_f};
  wire [7:0] wbyte_next = lsb_first ? {sdio_f, wsh_q[7:1]} :
                                      {wsh_q[6:0], sdio_f};
  wire instr_end = sclk_rise & (state_q == SCP_INSTR) &
                   (cnt_q == 4'hF);
  wire byte_end = sclk_rise & (state_q == SCP_DATA) &
                  (cnt_q[2:0] == 3'h7);
  wire [12:0] addr_step = lsb_first ? addr_q + 13'h0001 :
                                      addr_q - 13'h0001;

  // Write commit decode
  wire wr_in = addr_q <= ADDR_LAST;
  wire [5:0] wr_idx = addr_q[5:0];
  wire wr_byte = byte_end & ~dir_q;
  wire upd_hit = wr_byte & (addr_q == ADDR_UPDATE) &
                 wbyte_next[UPDATE_BIT];
  wire stage_en = wr_byte & wr_in & ~READ_ONLY_MAP[wr_idx] &
                  (addr_q != ADDR_UPDATE);

  // Read data source: next byte address, active or staged copy
  wire [12:0] rd_addr = instr_end ? instr_next[12:0] : addr_step;
  wire [5:0] rd_idx = rd_addr[5:0];
  wire rd_in = rd_addr <= ADDR_LAST;
  wire [7:0] rd_value =
    !rd_in ? 8'h00 :
    READ_ONLY_MAP[rd_idx] ? ro_data :
    (rd_addr == ADDR_UPDATE) ? 8'h00 :
    rd_staged ? staged_q[rd_idx] : active_q[rd_idx];

  // Select rise mid-byte, after streaming or when finished ends the cycle
  wire end_cycle = cs_rise & (state_q != SCP_IDLE) &
                   ((cnt_q[2:0] != 3'h0) | (state_q == SCP_DONE) |
                    ((state_q == SCP_DATA) & stream_q));

  // Edge history
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_f;
      cs_prev_q <= cs_f;
    end
  end

  // Port state machine; select high on a byte boundary simply holds
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SCP_IDLE;
      cnt_q <= 4'h0;
      instr_q <= 16'h0000;
      dir_q <= 1'b0;
      stream_q <= 1'b0;
      left_q <= 2'h0;
      addr_q <= 13'h0000;
      wsh_q <= 8'h00;
    end else if (end_cycle) begin
      state_q <= SCP_IDLE;
      cnt_q <= 4'h0;
    end else if (cs_fall && state_q == SCP_IDLE) begin
      state_q <= SCP_INSTR;
      cnt_q <= 4'h0;
    end else if (sclk_rise) begin
      unique case (state_q)
        SCP_INSTR: begin
          instr_q <= instr_next;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'hF) begin
            dir_q <= instr_next[DIR_POS];
            stream_q <= instr_next[LEN_HI:LEN_LO] == LEN_STREAM;
            left_q <= instr_next[LEN_HI:LEN_LO];
            addr_q <= instr_next[ADDR_W-1:0];
            state_q <= SCP_DATA;
          end
        end
        SCP_DATA: begin
          cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
          wsh_q <= wbyte_next;
          if (cnt_q[2:0] == 3'h7) begin
            addr_q <= addr_step;
            if (!stream_q) begin
              if (left_q == 2'h0) begin
                state_q <= SCP_DONE;
              end else begin
                left_q <= left_q - 2'h1;
              end
            end
          end
        end
        SCP_IDLE, SCP_DONE: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // Read shifter: load at byte start, present one bit per falling edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rsh_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (cs_f || end_cycle) begin
      oe_q <= 1'b0;
    end else if (instr_end || (byte_end && dir_q)) begin
      rsh_q <= rd_value;
    end else if (sclk_fall && state_q == SCP_DATA && dir_q) begin
      sdo_q <= lsb_first ? rsh_q[0] : rsh_q[7];
      rsh_q <= lsb_first ? {1'b0, rsh_q[7:1]} : {rsh_q[6:0], 1'b0};
      oe_q <= 1'b1;
    end
  end

  // Staged and active register copies; update moves all at once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        staged_q[i] <= (i == 0) ? PORT_CFG_RST : REG_RST;
        active_q[i] <= (i == 0) ? PORT_CFG_RST : REG_RST;
      end
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd_hit;
      if (stage_en) begin
        staged_q[wr_idx] <= wbyte_next;
      end
      if (upd_hit) begin
        active_q <= staged_q;
      end
    end
  end

  // Link and user-side outputs straight from flip-flops
  assign link.dev_sdo = sdo_q;
  assign link.dev_oe = oe_q;
  assign update_pulse = upd_q;

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_cfg
    assign cfg_active[g*8 +: 8] = active_q[g];
  end

endmodule : scp_dev

// >>> scp_host.sv
// Serial master end: APB-controlled driver of the three-wire link
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module scp_host
  import scp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  scp_link_if.host link
);

  // Read bits take about nine cycles to return through both samplers
  if (HALF_CYC < 5 || HALF_CYC > 255) begin : g_bad_half_cyc
    $error("scp_host: HALF_CYC out of range");
  end

  scp_host_state_type state_q;
  logic [15:0] instr_q;
  logic [1:0] cnt_q;
  logic lsb_q, busy_q, done_q;
  logic [31:0] txd_q, rxd_q, prdata_q;
  logic pready_q, pslverr_q;
  logic [7:0] div_q;
  logic [5:0] pos_q;
  logic sclk_q, cs_q, sdo_q, oe_q;
  logic s1_q, s2_q, s3_q, sdio_f_q;

  // Bit index inside instruction or data word for a link position
  function automatic logic [4:0] bit_idx(input logic [5:0] p,
                                         input logic lsb);
    logic [5:0] off;
    off = p - 6'd16;
    if (p < 6'd16) begin
      bit_idx = {1'b0, lsb ? p[3:0] : ~p[3:0]};
    end else begin
      bit_idx = {off[4:3], lsb ? off[2:0] : ~off[2:0]};
    end
  endfunction : bit_idx

  // APB decode
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pready_q & pwrite;
  wire hit_ctrl = paddr == HOST_CTRL;
  wire hit_tx = paddr == HOST_TXDATA;
  wire hit_rx = paddr == HOST_RXDATA;
  wire hit_stat = paddr == HOST_STATUS;
  wire mapped = hit_ctrl | hit_tx | hit_rx | hit_stat;
  wire [31:0] ctrl_rd = {1'b0, lsb_q, 11'h000, 1'b0, cnt_q, instr_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_tx ? txd_q :
                       hit_rx ? rxd_q :
                       hit_stat ? {30'h0000_0000, done_q, busy_q} :
                       32'h0000_0000;
  wire go = wr_acc & hit_ctrl & pwdata[CTRL_GO] & ~busy_q;
  wire done_clr = wr_acc & hit_stat & pwdata[STAT_DONE];

  // Link sequencing helpers
  wire is_read = instr_q[DIR_POS];
  wire [2:0] nbytes = (instr_q[LEN_HI:LEN_LO] == LEN_STREAM) ?
                      {1'b0, cnt_q} + 3'h1 :
                      {1'b0, instr_q[LEN_HI:LEN_LO]} + 3'h1;
  wire [5:0] last_pos = 6'd15 + {nbytes, 3'b000};
  wire tick = div_q == 8'(HALF_CYC - 1);
  wire [5:0] nxt_pos = pos_q + 6'd1;
  wire [4:0] cur_idx = bit_idx(pos_q, lsb_q);
  wire [4:0] nxt_idx = bit_idx(nxt_pos, lsb_q);
  wire nxt_bit = (nxt_pos < 6'd16) ? instr_q[nxt_idx[3:0]] : txd_q[nxt_idx];
  wire nxt_oe = (nxt_pos < 6'd16) | ~is_read;
  wire rx_take = (state_q == SCP_H_HIGH) & tick & is_read &
                 (pos_q >= 6'd16);

  // APB register file
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instr_q <= 16'h0000;
      cnt_q <= 2'h0;
      lsb_q <= 1'b0;
      txd_q <= 32'h0000_0000;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup) begin
        prdata_q <= rd_mux;
        pslverr_q <= ~mapped;
      end
      if (wr_acc && hit_ctrl && !busy_q) begin
        instr_q <= pwdata[15:0];
        cnt_q <= pwdata[CTRL_CNT_LO +: 2];
        lsb_q <= pwdata[CTRL_LSB];
      end
      if (wr_acc && hit_tx && !busy_q) begin
        txd_q <= pwdata;
      end
    end
  end

  // Three-stage sampling of the shared data line
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sdio_f_q <= 1'b1;
    end else begin
      s1_q <= link.sdio;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sdio_f_q <= s2_q;
      end
    end
  end

  // Frame sequencer: select low, 16 + 8N clock periods, select high
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SCP_H_IDLE;
      div_q <= 8'h00;
      pos_q <= 6'h00;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rxd_q <= 32'h0000_0000;
    end else begin
      div_q <= (tick || state_q == SCP_H_IDLE) ? 8'h00 : div_q + 8'h01;
      if (done_clr) begin
        done_q <= 1'b0;
      end
      if (rx_take) begin
        rxd_q[cur_idx] <= sdio_f_q;  // Sampled late in the high phase
      end
      unique case (state_q)
        SCP_H_IDLE: begin
          if (go) begin
            cs_q <= 1'b0;
            busy_q <= 1'b1;
            pos_q <= 6'h3F;
            rxd_q <= 32'h0000_0000;
            state_q <= SCP_H_SETUP;
          end
        end
        SCP_H_SETUP: begin
          if (tick) begin
            pos_q <= nxt_pos;
            sdo_q <= nxt_bit;
            oe_q <= 1'b1;
            state_q <= SCP_H_LOW;
          end
        end
        SCP_H_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            state_q <= SCP_H_HIGH;
          end
        end
        SCP_H_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            if (pos_q == last_pos) begin
              oe_q <= 1'b0;
              state_q <= SCP_H_END;
            end else begin
              pos_q <= nxt_pos;
              sdo_q <= nxt_bit;
              oe_q <= nxt_oe;  // Hands the line over for read data
              state_q <= SCP_H_LOW;
            end
          end
        end
        SCP_H_END: begin
          if (tick) begin
            cs_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;  // Set wins over a same-cycle clear
            state_q <= SCP_H_IDLE;
          end
        end
        default: begin
          state_q <= SCP_H_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.host_sdo = sdo_q;
  assign link.host_oe = oe_q;

endmodule : scp_host

// >>> scp_link_props.sv
// Concurrent checks on the three-wire link between host and device
`timescale 1ns/1ps
module scp_link_props #(
  parameter int HALF_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdo,
  input wire logic host_oe,
  input wire logic dev_sdo,
  input wire logic dev_oe,
  input wire logic sdio
);
  logic sclk_q;
  logic [7:0] rise_q;
  logic [7:0] high_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Count shift-clock rises per frame and cycles spent high
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      rise_q <= 8'h00;
      high_q <= 8'h00;
    end else begin
      sclk_q <= sclk;
      rise_q <= cs_n ? 8'h00 : rise_q + {7'h00, sclk & ~sclk_q};
      high_q <= sclk ? high_q + 8'h01 : 8'h00;
    end
  end

  // Steps of a frame
  sequence s_deselected;
    cs_n [*6];
  endsequence
  sequence s_instr_rise;
    sclk && !sclk_q && rise_q < 8'h10;
  endsequence
  sequence s_turnaround;
    $rose(dev_oe);
  endsequence

  a_release_deselect: assert property (s_deselected |-> !dev_oe)
    else $error("device drives data line while deselected");
  a_single_driver: assert property (!(dev_oe && host_oe) &&
    (!dev_oe || sdio == dev_sdo))
    else $error("data line driven by both ends or not by device");
  a_read_on_fall: assert property (
    dev_oe && $past(dev_oe) && $changed(dev_sdo) |-> !sclk)
    else $error("read data changed while shift clock high");
  a_oe_after_instr: assert property (s_turnaround |->
    !sclk && !cs_n && rise_q == 8'h10)
    else $error("device drove line outside read turnaround");
  a_write_stable: assert property (
    sclk && sclk_q && host_oe && $past(host_oe) |-> $stable(host_sdo))
    else $error("write data moved while shift clock high");
  a_idle_clock: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("shift clock active outside a frame");
  a_frame_bytes: assert property ($rose(cs_n) |->
    rise_q >= 8'h18 && rise_q[2:0] == 3'h0)
    else $error("frame not whole bytes after instruction");
  a_instr_by_host: assert property (s_instr_rise |->
    host_oe && !dev_oe)
    else $error("instruction bit not driven by host");
  a_shift_high: assert property ($fell(sclk) |->
    high_q == 8'(HALF_CYC))
    else $error("shift clock high time wrong");
endmodule : scp_link_props

// >>> tb_three_wire_serial_control_port.sv
// Testbench joining host and device ends over the three-wire link
`timescale 1ns/1ps
module tb_three_wire_serial_control_port
  import scp_pkg::*;
;
  // Link divider slow enough for the read-data round trip
  localparam int HC = SCLK_HALF_CYC;
  logic sys_clk;
  logic rstn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [NUM_REGS*8-1:0] cfg_active;
  logic update_pulse;
  logic [7:0] ro_data;
  logic [31:0] rx_v;
  logic [15:0] mon;
  logic lsb_sel = 1'b0;
  int mcnt = 0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int upd_n = 0;

  scp_link_if link();
  scp_dev u_scp_dev (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .ro_data(ro_data), .cfg_active(cfg_active),
    .update_pulse(update_pulse));
  scp_host #(.HALF_CYC(HC)) u_scp_host (.sys_clk(sys_clk), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  scp_link_props #(.HALF_CYC(HC)) u_scp_link_props (.sys_clk(sys_clk),
    .rstn(rstn), .sclk(link.sclk), .cs_n(link.cs_n),
    .host_sdo(link.host_sdo), .host_oe(link.host_oe),
    .dev_sdo(link.dev_sdo), .dev_oe(link.dev_oe), .sdio(link.sdio));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard and update pulse counter
  always @(posedge sys_clk) begin
    cyc++;
    if (update_pulse === 1'b1) upd_n++;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end

  // Capture the instruction word seen on the wire
  always @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) mcnt = 0;
    else if (mcnt < 16) begin
      mon = {mon[14:0], link.sdio};
      mcnt++;
    end
  end

  task summarize;
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] instr(input logic rd, input logic [1:0] len,
                                        input logic [12:0] a);
    return {rd, len, a};
  endfunction : instr

  function automatic logic [31:0] act(input int a);
    return {24'h00_0000, cfg_active[a*8 +: 8]};
  endfunction : act

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One link frame: load data, start, wait for done, fetch read data
  task run(input logic [15:0] ins, input logic [1:0] sc,
           input logic [31:0] tx, output logic [31:0] rx);
    int n;
    n = 0;
    rx = 32'h0000_0000;
    apb(HOST_TXDATA, 1'b1, tx, rx);
    apb(HOST_CTRL, 1'b1, {1'b1, lsb_sel, 12'h000, sc, ins}, rx);
    // Control word read during setup must not pass for a done flag
    rx = 32'h0000_0000;
    while (rx[STAT_DONE] !== 1'b1 && n < 4000) begin
      apb(HOST_STATUS, 1'b0, 32'h0000_0000, rx);
      n++;
    end
    chk("status", 32'h0000_0002, {30'h0, rx[1:0]});
    apb(HOST_STATUS, 1'b1, 32'h0000_0002, rx);
    apb(HOST_RXDATA, 1'b0, 32'h0000_0000, rx);
  endtask : run

  task wr1(input logic [12:0] a, input logic [7:0] d);
    run(instr(1'b0, 2'b00, a), 2'b00, {24'h00_0000, d}, rx_v);
  endtask : wr1

  task rd1(input logic [12:0] a, input logic [7:0] exp);
    run(instr(1'b1, 2'b00, a), 2'b00, 32'h0000_0000, rx_v);
    chk("read_byte", {24'h00_0000, exp}, rx_v & 32'h0000_00FF);
  endtask : rd1

  task t_reset;
    chk("port_cfg", {24'h00_0000, PORT_CFG_RST}, act(0));
    chk("reg10", {24'h00_0000, REG_RST}, act(16));
    chk("cs_n", 32'h0000_0001, {31'h0, link.cs_n});
    chk("dev_oe", 32'h0000_0000, {31'h0, link.dev_oe});
  endtask : t_reset

  task t_stage_update;
    wr1(13'h0010, 8'hA5);
    chk("instr_word", {16'h0000, instr(1'b0, 2'b00, 13'h0010)},
        {16'h0000, mon});
    chk("staged_only", 32'h0000_0000, act(16));
    wr1(ADDR_UPDATE, 8'h01);
    chk("update_cnt", 32'h0000_0001, 32'(upd_n));
    chk("active10", 32'h0000_00A5, act(16));
  endtask : t_stage_update

  task t_multi_read;
    logic [31:0] m;
    run(instr(1'b0, 2'b10, 13'h0022), 2'b00, 32'h0033_2211, rx_v);
    wr1(ADDR_UPDATE, 8'h01);
    chk("active20", 32'h0000_0033, act(32));
    for (int l = 0; l < 4; l++) begin
      run(instr(1'b1, 2'(l), 13'h0022), 2'b11, 32'h0000_0000, rx_v);
      m = (l == 3) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (8 * (l + 1))) - 1);
      chk("read_instr", {16'h0000, instr(1'b1, 2'(l), 13'h0022)},
          {16'h0000, mon});
      chk("read_len", 32'h0033_2211 & m, rx_v & m);
    end
  endtask : t_multi_read

  task t_stream_write;
    run(instr(1'b0, 2'b11, 13'h0030), 2'b01, 32'h0000_BBAA, rx_v);
    wr1(ADDR_UPDATE, 8'h01);
    chk("stream30", 32'h0000_00AA, act(48));
    chk("stream2f", 32'h0000_00BB, act(47));
    chk("stream2e", 32'h0000_0000, act(46));
  endtask : t_stream_write

  task t_read_only;
    wr1(13'h0002, 8'h5A);
    wr1(13'h0035, 8'h77);
    wr1(ADDR_UPDATE, 8'h01);
    rd1(13'h0002, 8'h3C);
    rd1(13'h0035, 8'h00);
  endtask : t_read_only

  task t_readback;
    wr1(ADDR_READBACK, 8'h01);
    wr1(ADDR_UPDATE, 8'h01);
    wr1(13'h0010, 8'h77);
    rd1(13'h0010, 8'h77);
    chk("active_kept", 32'h0000_00A5, act(16));
    wr1(ADDR_READBACK, 8'h00);
    wr1(ADDR_UPDATE, 8'h01);
    chk("active_new", 32'h0000_0077, act(16));
  endtask : t_readback

  // LSB-first order: address climbs, then back to MSB-first
  task t_lsb_first;
    wr1(ADDR_PORT_CFG, 8'h5A);
    wr1(ADDR_UPDATE, 8'h01);
    chk("port_cfg_lsb", 32'h0000_005A, act(0));
    lsb_sel = 1'b1;
    run(instr(1'b0, 2'b01, 13'h0028), 2'b00, 32'h0000_C2C1, rx_v);
    wr1(ADDR_UPDATE, 8'h01);
    chk("lsb28", 32'h0000_00C1, act(40));
    chk("lsb29", 32'h0000_00C2, act(41));
    run(instr(1'b1, 2'b01, 13'h0028), 2'b00, 32'h0000_0000, rx_v);
    chk("lsb_read", 32'h0000_C2C1, rx_v);
    wr1(ADDR_PORT_CFG, PORT_CFG_RST);
    wr1(ADDR_UPDATE, 8'h01);
    lsb_sel = 1'b0;
    chk("port_cfg_msb", {24'h00_0000, PORT_CFG_RST}, act(0));
    rd1(13'h0028, 8'hC1);
  endtask : t_lsb_first

  task t_apb_unmapped;
    apb(12'h010, 1'b0, 32'h0000_0000, rx_v);
    chk("unmapped_data", 32'h0000_0000, rx_v);
    chk("unmapped_err", 32'h0000_0001, {31'h0, last_err});
  endtask : t_apb_unmapped

  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ro_data = 8'h3C;
    repeat (8) @(posedge sys_clk);
    t_reset();
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_stage_update();
    t_multi_read();
    t_stream_write();
    t_read_only();
    t_readback();
    t_lsb_first();
    t_apb_unmapped();
    summarize();
  end
endmodule : tb_three_wire_serial_control_port
